/* File: verilog/ldd_top.sv */
// Purpose: serial command front end and scan driver of a four-digit LED driver
// Assumes: host stops shift_clock_i while latch_strobe_i is high
// Notes: link logic runs on shift_clock_i, display logic on clk_i
//
// Behaviour
// - Shift register advances on each shift clock
// - Frame is address byte then data byte
// - Strobe rise captures upper byte
// - Strobe fall writes lower byte to target
// - Targets: duty, decode/digits, four data
// - Shifted bits appear on serial output
// - Four digit selects scanned in turn
// - Eight segment outputs from scanned digit
// - Decoder gives numerals, letters, blank
// - Raw mode drives thirty-two single LEDs
// - Top nibble mode, next nibble register
// - Frames shifted most significant bit first
// - Duty in sixteen steps, zero to fifteen
`timescale 1ns/1ps
`include "ldd_map.svh"

module ldd_top (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic shift_clock_i,
    input wire logic serial_data_in_i,
    input wire logic latch_strobe_i,
    output logic serial_data_out_o,
    output logic [7:0] segment_drive_o,
    output logic [3:0] digit_select_o,
    output ldd_pkg::ldd_mode_t display_mode_o
);
    import ldd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Decoder: bit 0 is segment a, bit 6 is g, bit 7 the decimal point
    function automatic logic [7:0] ldd_decode(input logic [7:0] code);
        logic [6:0] pat;
        pat = 7'h00;
        case (code[3:0])
            4'h0: pat = 7'h3f;
            4'h1: pat = 7'h06;
            4'h2: pat = 7'h5b;
            4'h3: pat = 7'h4f;
            4'h4: pat = 7'h66;
            4'h5: pat = 7'h6d;
            4'h6: pat = 7'h7d;
            4'h7: pat = 7'h07;
            4'h8: pat = 7'h7f;
            4'h9: pat = 7'h6f;
            4'ha: pat = 7'h40; // Dash
            4'hb: pat = 7'h79; // E
            4'hc: pat = 7'h76; // H
            4'hd: pat = 7'h38; // L
            4'he: pat = 7'h73; // P
            default: pat = 7'h00; // Blank
        endcase
        return {code[7], pat};
    endfunction : ldd_decode

    ////////////////////////////////////////////////////////////////////////
    // Link domain: shift register
    logic [15:0] link_sreg;

    always_ff @(posedge shift_clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link_sreg <= 16'h0000;
        end else begin
            link_sreg <= {link_sreg[14:0], serial_data_in_i};
        end
    end

    // Duplicate flop so the pin comes straight from a register
    always_ff @(posedge shift_clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            serial_data_out_o <= 1'b0;
        end else begin
            serial_data_out_o <= link_sreg[14];
        end
    end

    property p_shift;
        @(posedge shift_clock_i) disable iff (sys_rst_i)
        1'b1 |=> link_sreg == {$past(link_sreg[14:0]), $past(serial_data_in_i)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift register did not advance");

    property p_sout;
        @(posedge shift_clock_i) disable iff (sys_rst_i)
        ##1 serial_data_out_o == link_sreg[15];
    endproperty
    a_sout: assert property (p_sout) else $error("serial out not the msb");

    ////////////////////////////////////////////////////////////////////////
    // Strobe crossing; the frame is quiet while the strobe is high, so the
    // synchronised edge qualifies a stable multi-bit copy of link_sreg
    logic strobe_s1;
    logic strobe_s2;
    logic strobe_s3;
    logic strobe_rise;
    logic strobe_fall;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            strobe_s1 <= 1'b0;
            strobe_s2 <= 1'b0;
            strobe_s3 <= 1'b0;
        end else begin
            strobe_s1 <= latch_strobe_i;
            strobe_s2 <= strobe_s1;
            strobe_s3 <= strobe_s2;
        end
    end

    assign strobe_rise = strobe_s2 && !strobe_s3;
    assign strobe_fall = !strobe_s2 && strobe_s3;

    ////////////////////////////////////////////////////////////////////////
    // Command registers
    logic [7:0] frame_hi;
    logic [3:0] duty;
    logic [3:0] decode_en;
    logic [1:0] digits_last;
    logic [7:0] digit_data [4];
    logic [3:0] hi_mode;
    logic [3:0] hi_sel;
    logic cmd_clear;

    assign hi_mode = frame_hi[`LDD_MODE_HI-8:`LDD_MODE_LO-8];
    assign hi_sel = frame_hi[`LDD_SEL_HI-8:`LDD_SEL_LO-8];
    assign cmd_clear = strobe_fall && hi_mode == `LDD_MODE_STANDBY
        && link_sreg[`LDD_CLEAR_BIT];

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            frame_hi <= 8'h00;
        end else if (strobe_rise) begin
            frame_hi <= link_sreg[15:8];
        end
    end

    property p_hi_capture;
        @(posedge clk_i) disable iff (sys_rst_i)
        strobe_rise |=> frame_hi == $past(link_sreg[15:8]);
    endproperty
    a_hi_capture: assert property (p_hi_capture) else $error("upper byte not captured");

    // Only a strobe fall writes; shifting alone leaves these alone
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            duty <= `LDD_RST_DUTY;
            decode_en <= `LDD_RST_DECODE;
            digits_last <= `LDD_RST_DIGITS;
            for (int i = 0; i < 4; i++) begin
                digit_data[i] <= `LDD_RST_DATA;
            end
        end else if (cmd_clear) begin
            duty <= `LDD_RST_DUTY;
            decode_en <= `LDD_RST_DECODE;
            digits_last <= `LDD_RST_DIGITS;
            for (int i = 0; i < 4; i++) begin
                digit_data[i] <= `LDD_RST_DATA;
            end
        end else if (strobe_fall && hi_mode == `LDD_MODE_LOAD) begin
            case (hi_sel)
                `LDD_SEL_DUTY: duty <= link_sreg[`LDD_DUTY_HI:`LDD_DUTY_LO];
                `LDD_SEL_DECDIG: begin
                    decode_en <= link_sreg[`LDD_DEC_HI:`LDD_DEC_LO];
                    digits_last <= link_sreg[`LDD_DIG_HI:`LDD_DIG_LO];
                end
                default: begin
                    if (hi_sel >= `LDD_SEL_DATA0 && hi_sel <= `LDD_SEL_DATA3) begin
                        digit_data[2'(hi_sel - `LDD_SEL_DATA0)] <= link_sreg[7:0];
                    end
                end
            endcase
        end
    end

    property p_duty_write;
        @(posedge clk_i) disable iff (sys_rst_i)
        strobe_fall && hi_mode == `LDD_MODE_LOAD && hi_sel == `LDD_SEL_DUTY
        |=> duty == $past(link_sreg[`LDD_DUTY_HI:`LDD_DUTY_LO]);
    endproperty
    a_duty_write: assert property (p_duty_write) else $error("duty not written");

    property p_quiet;
        @(posedge clk_i) disable iff (sys_rst_i)
        !strobe_fall |=> $stable(duty) && $stable(decode_en) && $stable(digit_data[0]);
    endproperty
    a_quiet: assert property (p_quiet) else $error("register changed without strobe");

    // Load frames leave the display mode as it was
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            display_mode_o <= LDD_BLANK;
        end else if (cmd_clear) begin
            display_mode_o <= LDD_BLANK;
        end else if (strobe_fall) begin
            case (hi_mode)
                `LDD_MODE_BLANK: display_mode_o <= LDD_BLANK;
                `LDD_MODE_NORMAL: display_mode_o <= LDD_NORMAL;
                `LDD_MODE_ALLON: display_mode_o <= LDD_ALLON;
                `LDD_MODE_STANDBY: display_mode_o <= LDD_STANDBY;
                default: display_mode_o <= display_mode_o;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scan: each digit slot is sixteen duty steps long
    localparam int STEP_CYC = `LDD_STEP_CYC;
    logic [7:0] step_cnt;
    logic [3:0] sub_step;
    logic [1:0] scan_idx;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            step_cnt <= 8'h00;
            sub_step <= 4'h0;
            scan_idx <= 2'h0;
        end else if (step_cnt == 8'(STEP_CYC - 1)) begin
            step_cnt <= 8'h00;
            sub_step <= sub_step + 4'h1;
            if (sub_step == 4'hf) begin
                scan_idx <= (scan_idx >= digits_last) ? 2'h0 : scan_idx + 2'h1;
            end
        end else begin
            step_cnt <= step_cnt + 8'h01;
        end
    end

    logic digit_on;
    logic [3:0] digit_onehot;
    logic [7:0] next_segments;
    assign digit_on = sub_step < duty && scan_idx <= digits_last;
    assign digit_onehot = digit_on ? 4'(1 << scan_idx) : 4'h0;
    // Raw data lets four digits act as thirty-two single LEDs
    assign next_segments = decode_en[scan_idx] ? ldd_decode(digit_data[scan_idx])
        : digit_data[scan_idx];

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            segment_drive_o <= 8'h00;
            digit_select_o <= 4'h0;
        end else begin
            case (display_mode_o)
                LDD_NORMAL: begin
                    segment_drive_o <= digit_on ? next_segments : 8'h00;
                    digit_select_o <= digit_onehot;
                end
                LDD_ALLON: begin
                    segment_drive_o <= 8'hff;
                    digit_select_o <= digit_onehot;
                end
                default: begin
                    segment_drive_o <= 8'h00;
                    digit_select_o <= 4'h0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_onehot;
        @(posedge clk_i) disable iff (sys_rst_i)
        $onehot0(digit_select_o);
    endproperty
    a_onehot: assert property (p_onehot) else $error("more than one digit selected");

    property p_blank;
        @(posedge clk_i) disable iff (sys_rst_i)
        display_mode_o == LDD_BLANK |=> digit_select_o == 4'h0 && segment_drive_o == 8'h00;
    endproperty
    a_blank: assert property (p_blank) else $error("blank mode drives outputs");

    property p_allon;
        @(posedge clk_i) disable iff (sys_rst_i)
        display_mode_o == LDD_ALLON |=> segment_drive_o == 8'hff;
    endproperty
    a_allon: assert property (p_allon) else $error("all-on mode not lit");

    property p_duty_zero;
        @(posedge clk_i) disable iff (sys_rst_i)
        duty == 4'h0 |=> digit_select_o == 4'h0;
    endproperty
    a_duty_zero: assert property (p_duty_zero) else $error("zero duty lit a digit");
endmodule : ldd_top

/* File: verilog/ldd_map.svh */
// Purpose: constants of the LED digit driver command front end
// Assumes: 16-bit frames, mode nibble on top, register nibble below it
// Notes: register select codes and scan step time are local choices
`ifndef LDD_MAP_SVH
`define LDD_MAP_SVH

`define LDD_FRAME_W 16
`define LDD_MODE_HI 15
`define LDD_MODE_LO 12
`define LDD_SEL_HI 11
`define LDD_SEL_LO 8

// Mode nibble codes
`define LDD_MODE_BLANK 4'h0
`define LDD_MODE_NORMAL 4'h1
`define LDD_MODE_LOAD 4'h2
`define LDD_MODE_ALLON 4'h3
`define LDD_MODE_STANDBY 4'h4

// Register select codes in load mode
`define LDD_SEL_DUTY 4'h0
`define LDD_SEL_DECDIG 4'h1
`define LDD_SEL_DATA0 4'h2
`define LDD_SEL_DATA3 4'h5

// Standby frame: low bit set means clear to initial state
`define LDD_CLEAR_BIT 0

// Data byte fields of load frames
`define LDD_DUTY_HI 3
`define LDD_DUTY_LO 0
`define LDD_DEC_HI 7
`define LDD_DEC_LO 4
`define LDD_DIG_HI 1
`define LDD_DIG_LO 0

// Reset values
`define LDD_RST_DUTY 4'hf
`define LDD_RST_DECODE 4'hf
`define LDD_RST_DIGITS 2'h3
`define LDD_RST_DATA 8'h00

// Scan timing: one duty step, as time and as clk_i cycles
`define LDD_CLK_MHZ 25
`define LDD_STEP_NS 1000
`define LDD_STEP_CYC ((`LDD_STEP_NS * `LDD_CLK_MHZ) / 1000)

`endif

/* File: verilog/ldd_pkg.sv */
// Purpose: types of the LED digit driver
// Assumes: nothing beyond the constant header
// Notes: display mode is held as an enum, frame codes live in the header
package ldd_pkg;
    typedef enum logic [2:0] {
        LDD_BLANK,
        LDD_NORMAL,
        LDD_ALLON,
        LDD_STANDBY
    } ldd_mode_t;
endpackage : ldd_pkg

/* File: testbench/ldd_host.sv */
// Purpose: host side of the serial command link
// Assumes: shift clock period 64 ns, idle low between frames
// Notes: data line shows the inverse of its last bit when released
`timescale 1ns/1ps

module ldd_host (
    output logic shift_clock_o,
    output logic serial_data_o,
    output logic latch_strobe_o,
    input wire logic serial_data_in_i
);
    initial begin
        shift_clock_o = 1'b0;
        serial_data_o = 1'b0;
        latch_strobe_o = 1'b0;
    end

    // Echo holds the cascade output seen just before each rise
    task automatic send(input logic [15:0] frame, input logic strobe, output logic [15:0] echo);
        for (int i = 15; i >= 0; i--) begin
            serial_data_o = frame[i];
            #32;
            echo[i] = serial_data_in_i;
            shift_clock_o = 1'b1;
            #32;
            shift_clock_o = 1'b0;
        end
        serial_data_o = ~frame[0];
        #100;
        if (strobe) begin
            latch_strobe_o = 1'b1;
            #200;
            latch_strobe_o = 1'b0;
            #280;
        end
    endtask : send
endmodule : ldd_host

/* File: testbench/testbench.sv */
// Purpose: self-checking bench of the LED digit driver
// Assumes: host model sends whole frames, strobe held 5 clk_i
// Notes: four-digit scan is 1600 clk_i, so full scans watch 1700 cycles, single-digit checks 500
`timescale 1ns/1ps
`include "ldd_map.svh"

module testbench;
    import ldd_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic shift_clock;
    logic serial_data;
    logic latch_strobe;
    logic serial_data_out;
    logic [7:0] segment_drive;
    logic [3:0] digit_select;
    ldd_mode_t display_mode;
    logic [15:0] echo;
    logic [3:0] seen;
    logic [7:0] seg0;
    logic [7:0] seg3;
    int fail_count = 0;
    int total_checks = 0;
    logic [3:0] m_code [5] = '{`LDD_MODE_BLANK, `LDD_MODE_ALLON, `LDD_MODE_STANDBY, 4'h5,
                               `LDD_MODE_NORMAL};
    ldd_mode_t m_exp [5] = '{LDD_BLANK, LDD_ALLON, LDD_STANDBY, LDD_STANDBY, LDD_NORMAL};
    logic [7:0] s_exp [5] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'ha5};

    always #20 clk_i = ~clk_i;

    ldd_top i_ldd_top (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .shift_clock_i(shift_clock),
        .serial_data_in_i(serial_data),
        .latch_strobe_i(latch_strobe),
        .serial_data_out_o(serial_data_out),
        .segment_drive_o(segment_drive),
        .digit_select_o(digit_select),
        .display_mode_o(display_mode)
    );

    ldd_host i_ldd_host (
        .shift_clock_o(shift_clock),
        .serial_data_o(serial_data),
        .latch_strobe_o(latch_strobe),
        .serial_data_in_i(serial_data_out)
    );

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic cmd(input logic [3:0] m, input logic [3:0] s, input logic [7:0] d);
        i_ldd_host.send({m, s, d}, 1'b1, echo);
        @(negedge clk_i);
    endtask : cmd

    // Captured patterns stay unknown if their digit never lights
    task automatic scan(input int n);
        seen = 4'h0;
        seg0 = 8'hxx;
        seg3 = 8'hxx;
        repeat (n) begin
            @(negedge clk_i);
            seen = seen | digit_select;
            if (digit_select === 4'h1) begin
                seg0 = segment_drive;
            end
            if (digit_select === 4'h8) begin
                seg3 = segment_drive;
            end
        end
    endtask : scan

    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    initial begin
        #2000000;
        fail_count++;
        finish_test();
    end

    initial begin
        repeat (10) @(negedge clk_i);
        sys_rst_i = 1'b0;
        check(display_mode, LDD_BLANK);
        check({segment_drive, digit_select}, 12'h000);
        $display("Test reset done");
        cmd(`LDD_MODE_NORMAL, 4'h0, 8'h00);
        check(display_mode, LDD_NORMAL);
        scan(1700);
        check(seen, 4'hf);
        check(seg0, 8'h3f);
        $display("Test default scan done");
        cmd(`LDD_MODE_LOAD, `LDD_SEL_DATA0, 8'h01);
        cmd(`LDD_MODE_LOAD, `LDD_SEL_DECDIG, 8'hf0);
        check(echo, {`LDD_MODE_LOAD, `LDD_SEL_DATA0, 8'h01});
        scan(1700);
        check(seen, 4'h1);
        check(seg0, 8'h06);
        i_ldd_host.send({`LDD_MODE_LOAD, `LDD_SEL_DATA0, 8'h7f}, 1'b0, echo);
        scan(500);
        check(seg0, 8'h06);
        $display("Test load and cascade done");
        cmd(`LDD_MODE_LOAD, `LDD_SEL_DECDIG, 8'h00);
        cmd(`LDD_MODE_LOAD, `LDD_SEL_DATA0, 8'ha5);
        scan(500);
        check(seg0, 8'ha5);
        cmd(`LDD_MODE_LOAD, `LDD_SEL_DUTY, 8'h00);
        scan(500);
        check(seen, 4'h0);
        check(display_mode, LDD_NORMAL);
        cmd(`LDD_MODE_LOAD, `LDD_SEL_DUTY, 8'h0f);
        $display("Test decode and duty done");
        for (int i = 0; i < 5; i++) begin
            cmd(m_code[i], 4'h0, 8'h00);
            check(display_mode, m_exp[i]);
            scan(500);
            check(seen, {3'h0, s_exp[i] != 8'h00});
            if (s_exp[i] != 8'h00) begin
                check(seg0, s_exp[i]);
            end
        end
        $display("Test modes done");
        cmd(`LDD_MODE_STANDBY, 4'h0, 8'h01);
        check(display_mode, LDD_BLANK);
        cmd(`LDD_MODE_NORMAL, 4'h0, 8'h00);
        scan(1700);
        check(seen, 4'hf);
        check(seg0, 8'h3f);
        $display("Test clear done");
        cmd(`LDD_MODE_LOAD, `LDD_SEL_DATA3, 8'h8c);
        cmd(`LDD_MODE_LOAD, 4'h6, 8'h88);
        scan(1700);
        check(seg3, 8'hf6);
        check(seg0, 8'h3f);
        cmd(`LDD_MODE_LOAD, `LDD_SEL_DECDIG, 8'h73);
        scan(1700);
        check(seen, 4'hf);
        check(seg3, 8'h8c);
        $display("Test digit three done");
        finish_test();
    end
endmodule : testbench
